// ### rtl/rsc_relay_switch_control.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Write to register 3 loads one bit per channel; all ones closes all.
// - Read of register 3 returns latched relay drive state per channel.
// - Reset opens every relay and status reads zero.
// - Status latches drive state a fixed delay after a write.
// - Normal traffic only if terminal module fitted at wake-up identification.
// - Sixteen channels 0 to 15, fed from two eight-line driver groups.
module rsc_relay_switch_control #(
    parameter logic [4:0] CARD_ID = rsc_pkg::CARD_ID_DEFAULT,
    parameter logic [2:0] TERM_TYPE = rsc_pkg::TERM_TYPE_DEFAULT
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [rsc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic slot_register_write_in,
    input wire logic slot_register_read_in,
    input wire logic [rsc_pkg::DATA_W-1:0] wr_data_in,
    input wire logic terminal_present_in,
    output logic [rsc_pkg::DATA_W-1:0] rd_data_out,
    output logic rd_valid_out,
    output logic comm_ok_out,
    output logic [rsc_pkg::DATA_W-1:0] relay_drive_out
);
    localparam int NGROUPS = rsc_pkg::DATA_W / rsc_pkg::GROUP_W;

    initial begin
        if (rsc_pkg::LATCH_CYCLES < 2 || rsc_pkg::LATCH_CYCLES >= (1 << rsc_pkg::CNT_W)) begin
            $error("rsc_relay_switch_control: latch delay out of counter range");
        end
        if (rsc_pkg::DATA_W % rsc_pkg::GROUP_W != 0) begin
            $error("rsc_relay_switch_control: data width not whole driver groups");
        end
    end

    // Pin input, two stages before use
    logic term_meta_ff;
    logic term_sync_ff;
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            term_meta_ff <= 1'b0;
            term_sync_ff <= 1'b0;
        end else begin
            term_meta_ff <= terminal_present_in;
            term_sync_ff <= term_meta_ff;
        end
    end

    logic wake_ff;
    logic comm_ok_ff;
    logic [rsc_pkg::DATA_W-1:0] status_ff;
    logic [rsc_pkg::CNT_W-1:0] latch_cnt_ff;
    logic [rsc_pkg::DATA_W-1:0] rd_data_ff;
    logic rd_valid_ff;
    logic nxt_wake;
    logic nxt_comm_ok;
    logic [rsc_pkg::DATA_W-1:0] nxt_status;
    logic [rsc_pkg::CNT_W-1:0] nxt_latch_cnt;
    logic [rsc_pkg::DATA_W-1:0] nxt_rd_data;
    logic nxt_rd_valid;
    logic wr_acc;
    logic id_poll;

    // Presence is judged once, at the wake-up poll; later removal is not seen
    assign id_poll = slot_register_read_in && wake_ff && reg_addr_in == rsc_pkg::ID_REG_IDX;
    assign wr_acc = slot_register_write_in && comm_ok_ff && reg_addr_in == rsc_pkg::RELAY_REG_IDX;

    genvar g;
    generate
        for (g = 0; g < NGROUPS; g++) begin : g_drv
            rsc_driver_group #(
                .WIDTH(rsc_pkg::GROUP_W)
            ) u_grp (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .load_in(wr_acc),
                .bits_in(wr_data_in[g*rsc_pkg::GROUP_W +: rsc_pkg::GROUP_W]),
                .drive_out(relay_drive_out[g*rsc_pkg::GROUP_W +: rsc_pkg::GROUP_W])
            );
        end
    endgenerate

    always_comb begin
        nxt_wake = wake_ff;
        nxt_comm_ok = comm_ok_ff;
        nxt_status = status_ff;
        nxt_latch_cnt = latch_cnt_ff;
        nxt_rd_data = rsc_pkg::READ_ZERO;
        nxt_rd_valid = slot_register_read_in;
        if (id_poll) begin
            nxt_wake = 1'b0;
            nxt_comm_ok = term_sync_ff;
            nxt_rd_data = {8'h00, CARD_ID, term_sync_ff ? TERM_TYPE : rsc_pkg::TERM_ABSENT_CODE};
        end else if (slot_register_read_in && comm_ok_ff && reg_addr_in == rsc_pkg::RELAY_REG_IDX) begin
            nxt_rd_data = status_ff;
        end
        // Drive lines settle one edge after the write; status copies them later
        if (wr_acc) begin
            nxt_latch_cnt = rsc_pkg::CNT_W'(rsc_pkg::LATCH_CYCLES);
        end else if (latch_cnt_ff != '0) begin
            nxt_latch_cnt = latch_cnt_ff - 1'b1;
            if (latch_cnt_ff == 1) begin
                nxt_status = relay_drive_out;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            wake_ff <= 1'b1;
            comm_ok_ff <= 1'b0;
            status_ff <= rsc_pkg::RELAY_RESET;
            latch_cnt_ff <= '0;
            rd_data_ff <= rsc_pkg::READ_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            wake_ff <= nxt_wake;
            comm_ok_ff <= nxt_comm_ok;
            status_ff <= nxt_status;
            latch_cnt_ff <= nxt_latch_cnt;
            rd_data_ff <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign rd_data_out = rd_data_ff;
    assign rd_valid_out = rd_valid_ff;
    assign comm_ok_out = comm_ok_ff;

    a_write_loads_drive: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_acc |=> relay_drive_out == $past(wr_data_in))
        else $error("relay drive not loaded by write");

    a_all_ones_close: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_acc && wr_data_in == 16'hFFFF |=> relay_drive_out == 16'hFFFF)
        else $error("all ones did not close every relay");

    a_bit_channel_map: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_acc |=> relay_drive_out[0] == $past(wr_data_in[0]) && relay_drive_out[15] == $past(wr_data_in[15]))
        else $error("channel bit mapping wrong");

    a_upper_group: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_acc |=> relay_drive_out[15:8] == $past(wr_data_in[15:8]) && relay_drive_out[7:0] == $past(wr_data_in[7:0]))
        else $error("driver group split wrong");

    a_read_status: assert property (@(posedge clock_in) disable iff (rst_in)
        slot_register_read_in && comm_ok_ff && !wake_ff && reg_addr_in == rsc_pkg::RELAY_REG_IDX
        |=> rd_valid_out && rd_data_out == $past(status_ff))
        else $error("status read returned wrong value");

    a_reset_opens: assert property (@(posedge clock_in)
        rst_in |=> relay_drive_out == 16'h0000 && status_ff == 16'h0000 && !comm_ok_out)
        else $error("reset did not open relays");

    a_status_latch_delay: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_acc ##1 (!wr_acc)[*5] |=> status_ff == relay_drive_out)
        else $error("status not latched after delay");

    a_status_not_early: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_acc && latch_cnt_ff == 0 |=> $stable(status_ff))
        else $error("status latched too early");

    a_no_comm_ignored: assert property (@(posedge clock_in) disable iff (rst_in)
        slot_register_write_in && !comm_ok_ff |=> $stable(relay_drive_out))
        else $error("write accepted without terminal");

    a_wake_capture: assert property (@(posedge clock_in) disable iff (rst_in)
        id_poll |=> comm_ok_out == $past(term_sync_ff) && !wake_ff)
        else $error("presence not captured at wake poll");

    a_read_answer: assert property (@(posedge clock_in) disable iff (rst_in)
        slot_register_read_in |=> rd_valid_out)
        else $error("read strobe got no answer");

    a_idle_read_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        !slot_register_read_in |=> !rd_valid_out && rd_data_out == 16'h0000)
        else $error("answer shown without a read");

    a_unmapped_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        slot_register_read_in && reg_addr_in != rsc_pkg::RELAY_REG_IDX && reg_addr_in != rsc_pkg::ID_REG_IDX
        |=> rd_valid_out && rd_data_out == 16'h0000)
        else $error("unmapped read not zero");

    a_id_code: assert property (@(posedge clock_in) disable iff (rst_in)
        id_poll |=> rd_data_out[7:3] == CARD_ID && rd_data_out[15:8] == 8'h00)
        else $error("identification code wrong");

    a_absent_code: assert property (@(posedge clock_in) disable iff (rst_in)
        id_poll && !term_sync_ff |=> rd_data_out[2:0] == rsc_pkg::TERM_ABSENT_CODE)
        else $error("absent terminal code wrong");

    a_wake_once: assert property (@(posedge clock_in) disable iff (rst_in)
        !wake_ff |=> !wake_ff)
        else $error("wake state came back without reset");

    a_drive_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        !wr_acc |=> $stable(relay_drive_out))
        else $error("relay drive moved without a write");

    a_comm_hold: assert property (@(posedge clock_in) disable iff (rst_in)
        !wake_ff |=> $stable(comm_ok_out))
        else $error("communication enable moved after wake");

    a_latch_cnt_range: assert property (@(posedge clock_in) disable iff (rst_in)
        latch_cnt_ff <= rsc_pkg::CNT_W'(rsc_pkg::LATCH_CYCLES))
        else $error("latch counter out of range");
endmodule : rsc_relay_switch_control
`default_nettype wire

// ### inc/rsc_pkg.sv
`default_nettype none
package rsc_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int GROUP_W = 8;
    localparam logic [2:0] ID_REG_IDX = 3'h0;
    localparam logic [2:0] RELAY_REG_IDX = 3'h3;
    localparam logic [15:0] RELAY_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    // Identity value is arbitrary
    localparam logic [4:0] CARD_ID_DEFAULT = 5'h15;
    localparam logic [2:0] TERM_TYPE_DEFAULT = 3'h1;
    localparam logic [2:0] TERM_ABSENT_CODE = 3'h7;
    localparam int CLK_PERIOD_NS = 20;
    localparam int LATCH_TIME_NS = 100;
    localparam int LATCH_CYCLES = (LATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
endpackage : rsc_pkg
`default_nettype wire

// ### rtl/rsc_driver_group.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_driver_group #(
    parameter int WIDTH = 8
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] bits_in,
    output logic [WIDTH-1:0] drive_out
);
    logic [WIDTH-1:0] drive_ff;
    logic [WIDTH-1:0] nxt_drive;

    initial begin
        if (WIDTH < 1) begin
            $error("rsc_driver_group: WIDTH must be at least 1");
        end
    end

    always_comb begin
        nxt_drive = drive_ff;
        if (load_in) begin
            nxt_drive = bits_in;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            drive_ff <= '0;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    assign drive_out = drive_ff;
endmodule : rsc_driver_group
`default_nettype wire

// ### verification/rsc_ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module rsc_ctl_model (
    input wire logic clock_in,
    input wire logic [15:0] rd_data_in,
    input wire logic rd_valid_in,
    output logic [2:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [15:0] data_out
);
    initial begin
        addr_out = 3'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        data_out = 16'h0000;
    end
    // Called at a falling edge; released lines flip so stale values never pass
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        addr_out = a;
        data_out = d;
        wr_out = 1'b1;
        @(negedge clock_in);
        wr_out = 1'b0;
        addr_out = ~addr_out;
        data_out = ~data_out;
        // Idle cycle so the next call never reassigns a line in this step
        @(negedge clock_in);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic v);
        addr_out = a;
        rd_out = 1'b1;
        @(negedge clock_in);
        // Answer stands one cycle only, so take it before releasing
        d = rd_data_in;
        v = rd_valid_in;
        rd_out = 1'b0;
        addr_out = ~addr_out;
        @(negedge clock_in);
    endtask : rd
    task automatic settle();
        repeat (3) @(negedge clock_in);
    endtask : settle
endmodule : rsc_ctl_model
`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic clock_in, rst_in, term_in, wr, rd, vld, ok;
    logic [2:0] addr;
    logic [15:0] wdat, rdat, drv, got;
    int n_mismatch = 0, checks_done = 0, m_drive, m_status, m_comm;
    rsc_relay_switch_control rsc_relay_switch_control_i (.clock_in(clock_in), .rst_in(rst_in),
        .reg_addr_in(addr), .slot_register_write_in(wr), .slot_register_read_in(rd), .wr_data_in(wdat),
        .terminal_present_in(term_in), .rd_data_out(rdat), .rd_valid_out(vld), .comm_ok_out(ok),
        .relay_drive_out(drv));
    rsc_ctl_model rsc_ctl_model_i (.clock_in(clock_in), .rd_data_in(rdat), .rd_valid_in(vld),
        .addr_out(addr), .wr_out(wr), .rd_out(rd), .data_out(wdat));
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic [2:0] a, input logic [15:0] e);
        logic v;
        rsc_ctl_model_i.rd(a, got, v);
        chk({15'h0000, v}, 16'h0001);
        chk(got, e);
    endtask : rdc
    task automatic wake(input logic p);
        rst_in = 1'b1;
        term_in = p;
        repeat (10) @(negedge clock_in);
        chk(drv, 16'h0000);
        rst_in = 1'b0;
        repeat (2) @(negedge clock_in);
        m_drive = 0;
        m_status = 0;
        m_comm = p;
        rdc(3'h0, {8'h00, rsc_pkg::CARD_ID_DEFAULT, p ? rsc_pkg::TERM_TYPE_DEFAULT : rsc_pkg::TERM_ABSENT_CODE});
        chk({15'h0000, ok}, {15'h0000, p});
        rdc(3'h3, 16'h0000);
        $display("test wake done");
    endtask : wake
    task automatic wrc(input logic [2:0] a, input logic [15:0] d);
        rsc_ctl_model_i.wr(a, d);
        if (m_comm == 1 && a == 3'h3) m_drive = d;
        chk(drv, 16'(m_drive));
        rdc(3'h3, 16'(m_status));
        m_status = m_drive;
        rsc_ctl_model_i.settle();
        rdc(3'h3, 16'(m_status));
    endtask : wrc
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    initial begin
        rst_in = 1'b1;
        term_in = 1'b0;
        void'($urandom(94956));
        wake(1'b1);
        wrc(3'h3, 16'hFFFF);
        for (int n = 0; n < 16; n++) wrc(3'h3, 16'h0001 << n);
        $display("test channels done");
        // Terminal pulled after wake; writes must still be taken
        term_in = 1'b0;
        for (int n = 0; n < 12; n++) wrc(3'h3, 16'($urandom));
        wrc(3'h6, 16'h1234);
        rdc(3'h5, 16'h0000);
        rdc(3'h0, 16'h0000);
        $display("test patterns done");
        wake(1'b0);
        wrc(3'h3, 16'hFFFF);
        $display("test absent terminal done");
        final_report();
    end
    // Whole run needs about 315 cycles
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end
endmodule : tb
`default_nettype wire
